/* shared/hbpwm_pkg.sv */
package hbpwm_pkg;

    localparam int CNT_W = 16;
    localparam int NUM_PAIRS = 3;
    localparam int NUM_OUTS = 6;
    localparam int PRE_W = 8;

    typedef struct packed {
        logic [15:0] rise;
        logic [15:0] fall;
        logic [15:0] low_fall;
        logic [15:0] len;
    } pair_cfg_t;

    // Word offsets, byte address = index * 4
    localparam logic [4:0] IDX_MAIN_CONTROL = 5'h00;
    localparam logic [4:0] IDX_PAIR_FIRST = 5'h01;
    localparam logic [4:0] IDX_PAIR_LAST = 5'h0c;
    localparam logic [4:0] IDX_AUX_CONTROL = 5'h0d;
    localparam logic [4:0] IDX_IRQ_CLEAR = 5'h0e;
    localparam logic [4:0] IDX_IRQ_STATUS = 5'h0f;
    localparam logic [4:0] IDX_IRQ_MASK = 5'h10;
    localparam logic [4:0] IDX_TIMER0 = 5'h11;
    localparam int ADDR_LSB = 2;

    // modulator_main_control fields
    localparam int BIT_GLOBAL_EN = 0;
    localparam int BIT_BRIDGE = 1;
    localparam int BIT_DIR = 2;
    localparam int BIT_LOAD_REQ = 3;
    localparam int BIT_HIGH_OFF = 4;
    localparam int BIT_INV_ALL = 5;
    localparam int BIT_PRESCALE_LO = 6;
    localparam int BIT_BRIDGE_ENA = 9;
    localparam int BIT_TRIP_EN = 10;
    localparam int BIT_INV_LOW0 = 11;
    localparam int MAIN_W = 14;
    localparam logic [13:0] MAIN_RESET = 14'h0012;

    // modulator_aux_control: bit 0 restarts all pair timers
    localparam int BIT_AUX_RESTART = 0;

    // Interrupt status and mask layout
    localparam int IRQ_W = 4;
    localparam int BIT_IRQ_TRIP = 0;
    localparam int BIT_IRQ_WRAP0 = 1;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : hbpwm_pkg

/* src/pwm_pair.sv */
`timescale 1ns/1ps
`default_nettype none
module pwm_pair (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic tick,
    input wire logic restart,
    input wire logic load_req,
    input wire hbpwm_pkg::pair_cfg_t cfg,
    output logic high_out,
    output logic low_out,
    output logic wrap,
    output logic [15:0] count
);
    logic [15:0] c_rise;
    logic [15:0] c_fall;
    logic [15:0] c_low;
    logic [15:0] next_count;
    logic next_high;
    logic next_low;
    logic load_now;
    logic high_falls;

    assign wrap = tick & (count >= cfg.len);
    assign next_count = wrap ? 16'h0000 : 16'(count + 16'h0001);
    assign load_now = tick & load_req & (count == 16'h0000) &
        (next_count == 16'h0001);
    // Fall wins over rise when both compares match the same count
    assign next_high = (next_count == c_fall) ? 1'b0 :
        (next_count == c_rise) ? 1'b1 : high_out;
    assign high_falls = high_out & ~next_high;
    assign next_low = ((next_count == c_low) | high_falls) ? 1'b0 :
        (next_count == cfg.len) ? 1'b1 : low_out;

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            count <= 16'h0000;
            high_out <= 1'b0;
            low_out <= 1'b0;
        end else if (restart) begin
            count <= 16'h0000;
            high_out <= 1'b0;
            low_out <= 1'b0;
        end else if (tick) begin
            count <= next_count;
            high_out <= next_high;
            low_out <= next_low;
        end
    end

    // Rise, fall and low fall compares are shadowed and copied at period start while load_req is set; cfg.len is used unshadowed
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            c_rise <= 16'h0000;
            c_fall <= 16'h0000;
            c_low <= 16'h0000;
        end else if (load_now) begin
            c_rise <= cfg.rise;
            c_fall <= cfg.fall;
            c_low <= cfg.low_fall;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);

    chk_timer_wrap: assert property (
        tick && !restart && count >= cfg.len |=> count == 16'h0000)
        else $error("timer did not restart at period length");
    chk_high_rise: assert property (
        tick && !restart && next_count == c_rise && next_count != c_fall
        |=> high_out)
        else $error("high side did not rise at first compare");
    chk_high_fall: assert property (
        tick && !restart && next_count == c_fall |=> !high_out)
        else $error("high side did not fall at second compare");
    chk_low_follow: assert property (
        $fell(high_out) |-> !low_out)
        else $error("low side stayed high after high side fell");
    chk_load_copy: assert property (
        load_now && !restart |=> c_rise == $past(cfg.rise) &&
        c_low == $past(cfg.low_fall))
        else $error("compare shadow not loaded on 0 to 1 step");

endmodule : pwm_pair
`default_nettype wire

/* src/six_channel_hbridge_pwm.sv */
// The register offsets and register access over AXI4-Lite were decided locally.
`timescale 1ns/1ps
`default_nettype none
module six_channel_hbridge_pwm (
    input wire logic CLK_SYS,
    input wire logic NRST,
    input wire logic [31:0] AWADDR,
    input wire logic AWVALID,
    output logic AWREADY,
    input wire logic [31:0] WDATA,
    input wire logic [3:0] WSTRB,
    input wire logic WVALID,
    output logic WREADY,
    output logic [1:0] BRESP,
    output logic BVALID,
    input wire logic BREADY,
    input wire logic [31:0] ARADDR,
    input wire logic ARVALID,
    output logic ARREADY,
    output logic [31:0] RDATA,
    output logic [1:0] RRESP,
    output logic RVALID,
    input wire logic RREADY,
    input wire logic TRIP_N,
    output logic [5:0] PWM_OUT,
    output logic IRQ
);

    function automatic logic [7:0] presc_mask(input logic [2:0] code);
        presc_mask = 8'(({1'b0, 8'h01} << ({1'b0, code} + 4'h1)) - 9'h001);
    endfunction : presc_mask

    function automatic logic is_mapped(input logic [4:0] idx);
        is_mapped = idx <= hbpwm_pkg::IDX_TIMER0;
    endfunction : is_mapped

    function automatic logic [31:0] merge(input logic [31:0] old,
            input logic [31:0] data, input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                res[b*8 +: 8] = data[b*8 +: 8];
            end
        end
        merge = res;
    endfunction : merge

    // Bus state
    logic aw_held;
    logic w_held;
    logic [4:0] aw_idx;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic do_write;
    logic rd_take;
    logic [4:0] ar_idx;
    logic [31:0] rd_word;

    // Registers
    logic [13:0] main_ctrl;
    logic [15:0] cfg_word [12];
    hbpwm_pkg::pair_cfg_t cfg [3];
    logic [3:0] irq_status;
    logic [3:0] irq_mask;
    logic ctrl_written;

    // Datapath
    logic [7:0] pre_cnt;
    logic [7:0] mask;
    logic tick;
    logic restart;
    logic trip_meta;
    logic trip_sync;
    logic trip_fire;
    logic [5:0] raw;
    logic [5:0] shaped;
    logic [5:0] inverted;
    logic [5:0] next_out;
    logic [2:0] wrap;
    logic [15:0] count [3];
    logic [3:0] events;
    logic [3:0] clr_bits;
    logic [3:0] next_status;
    logic [31:0] wr_old;
    logic [31:0] wr_word;

    logic global_en;
    logic bridge;
    logic [2:0] prescale;

    assign global_en = main_ctrl[hbpwm_pkg::BIT_GLOBAL_EN];
    assign bridge = main_ctrl[hbpwm_pkg::BIT_BRIDGE];
    assign prescale = main_ctrl[hbpwm_pkg::BIT_PRESCALE_LO +: 3];

    // Write channel: address and data taken in either order
    assign AWREADY = ~aw_held;
    assign WREADY = ~w_held;
    assign do_write = aw_held & w_held & ~BVALID;
    assign ARREADY = ~RVALID;
    assign rd_take = ARVALID & ARREADY;
    assign ar_idx = ARADDR[hbpwm_pkg::ADDR_LSB +: 5];

    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_idx <= 5'h00;
            w_data <= 32'h00000000;
            w_strb <= 4'h0;
        end else begin
            if (AWVALID && AWREADY) begin
                aw_held <= 1'b1;
                aw_idx <= AWADDR[hbpwm_pkg::ADDR_LSB +: 5];
            end else if (do_write) begin
                aw_held <= 1'b0;
            end
            if (WVALID && WREADY) begin
                w_held <= 1'b1;
                w_data <= WDATA;
                w_strb <= WSTRB;
            end else if (do_write) begin
                w_held <= 1'b0;
            end
        end
    end

    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            BVALID <= 1'b0;
            BRESP <= hbpwm_pkg::RESP_OKAY;
        end else if (do_write) begin
            BVALID <= 1'b1;
            BRESP <= is_mapped(aw_idx) ? hbpwm_pkg::RESP_OKAY :
                hbpwm_pkg::RESP_SLVERR;
        end else if (BREADY) begin
            BVALID <= 1'b0;
        end
    end

    // Read mux
    always_comb begin
        rd_word = 32'h00000000;
        if (ar_idx == hbpwm_pkg::IDX_MAIN_CONTROL) begin
            rd_word = {18'h00000, main_ctrl};
        end else if (ar_idx >= hbpwm_pkg::IDX_PAIR_FIRST &&
                ar_idx <= hbpwm_pkg::IDX_PAIR_LAST) begin
            rd_word = {16'h0000, cfg_word[4'(ar_idx - 5'h01)]};
        end else if (ar_idx == hbpwm_pkg::IDX_IRQ_STATUS) begin
            rd_word = {28'h0000000, irq_status};
        end else if (ar_idx == hbpwm_pkg::IDX_IRQ_MASK) begin
            rd_word = {28'h0000000, irq_mask};
        end else if (ar_idx == hbpwm_pkg::IDX_TIMER0) begin
            rd_word = {16'h0000, count[0]};
        end
    end

    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            RVALID <= 1'b0;
            RDATA <= 32'h00000000;
            RRESP <= hbpwm_pkg::RESP_OKAY;
        end else if (rd_take) begin
            RVALID <= 1'b1;
            RDATA <= rd_word;
            RRESP <= is_mapped(ar_idx) ? hbpwm_pkg::RESP_OKAY :
                hbpwm_pkg::RESP_SLVERR;
        end else if (RREADY) begin
            RVALID <= 1'b0;
        end
    end

    // Register writes with byte strobes
    assign wr_old = (aw_idx == hbpwm_pkg::IDX_MAIN_CONTROL) ?
        {18'h00000, main_ctrl} :
        (aw_idx == hbpwm_pkg::IDX_IRQ_MASK) ? {28'h0000000, irq_mask} :
        (aw_idx >= hbpwm_pkg::IDX_PAIR_FIRST &&
         aw_idx <= hbpwm_pkg::IDX_PAIR_LAST) ?
        {16'h0000, cfg_word[4'(aw_idx - 5'h01)]} : 32'h00000000;
    assign wr_word = merge(wr_old, w_data, w_strb);

    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            main_ctrl <= hbpwm_pkg::MAIN_RESET;
            ctrl_written <= 1'b0;
        end else begin
            if (do_write && aw_idx == hbpwm_pkg::IDX_MAIN_CONTROL) begin
                main_ctrl <= wr_word[13:0];
                ctrl_written <= 1'b1;
            end
            // Trip beats a same-cycle write: safety over software intent
            if (trip_fire) begin
                main_ctrl[hbpwm_pkg::BIT_GLOBAL_EN] <= 1'b0;
            end
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < 12; gi++) begin : g_cfg
            always_ff @(posedge CLK_SYS or negedge NRST) begin
                if (!NRST) begin
                    cfg_word[gi] <= 16'h0000;
                end else if (do_write &&
                        aw_idx == 5'(gi + 1)) begin
                    cfg_word[gi] <= wr_word[15:0];
                end
            end
        end
    endgenerate

    // Trip pin synchroniser, active low
    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            trip_meta <= 1'b1;
            trip_sync <= 1'b1;
        end else begin
            trip_meta <= TRIP_N;
            trip_sync <= trip_meta;
        end
    end
    assign trip_fire = ~trip_sync &
        main_ctrl[hbpwm_pkg::BIT_TRIP_EN];

    // Prescaler: free counter, tick when the selected low bits are all ones
    assign mask = presc_mask(prescale);
    assign tick = &(pre_cnt | ~mask);
    assign restart = do_write && aw_idx == hbpwm_pkg::IDX_AUX_CONTROL &&
        w_strb[0] && w_data[hbpwm_pkg::BIT_AUX_RESTART];

    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            pre_cnt <= 8'h00;
        end else begin
            pre_cnt <= 8'(pre_cnt + 8'h01);
        end
    end

    generate
        for (gi = 0; gi < 3; gi++) begin : g_pair
            assign cfg[gi] = {cfg_word[gi*4], cfg_word[gi*4+1],
                cfg_word[gi*4+2], cfg_word[gi*4+3]};
            pwm_pair u_pair (
                .clk_sys(CLK_SYS),
                .nrst(NRST),
                .tick(tick),
                .restart(restart),
                .load_req(main_ctrl[hbpwm_pkg::BIT_LOAD_REQ]),
                .cfg(cfg[gi]),
                .high_out(raw[gi*2]),
                .low_out(raw[gi*2+1]),
                .wrap(wrap[gi]),
                .count(count[gi])
            );
        end
    endgenerate

    // Bridge steering of pairs 0 and 1; pair 2 stays standard
    logic hoff;
    logic bena;
    logic dir;
    assign hoff = main_ctrl[hbpwm_pkg::BIT_HIGH_OFF];
    assign bena = main_ctrl[hbpwm_pkg::BIT_BRIDGE_ENA];
    assign dir = main_ctrl[hbpwm_pkg::BIT_DIR];
    assign shaped[5:4] = raw[5:4];
    assign shaped[3:0] = !bridge ? raw[3:0] :
        hoff ? 4'h5 :
        !bena ? 4'h0 :
        dir ? {2'h0, raw[1:0]} : {raw[3:2], 2'h0};

    generate
        for (gi = 0; gi < 6; gi++) begin : g_inv
            if (gi % 2 == 1) begin : g_odd
                assign inverted[gi] = shaped[gi] ^
                    main_ctrl[hbpwm_pkg::BIT_INV_LOW0 + gi / 2] ^
                    main_ctrl[hbpwm_pkg::BIT_INV_ALL];
            end else begin : g_even
                assign inverted[gi] = shaped[gi] ^
                    main_ctrl[hbpwm_pkg::BIT_INV_ALL];
            end
        end
    endgenerate

    // Disabled outputs sit low regardless of inversion
    assign next_out = global_en ? inverted : 6'h00;

    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            PWM_OUT <= 6'h00;
        end else begin
            PWM_OUT <= next_out;
        end
    end

    // Interrupts: set wins over read-clear and clear-register write
    assign events = {wrap, trip_fire};
    assign clr_bits =
        ((rd_take && ar_idx == hbpwm_pkg::IDX_IRQ_STATUS) ||
         (do_write && aw_idx == hbpwm_pkg::IDX_IRQ_CLEAR)) ?
        4'hf : 4'h0;
    assign next_status = (irq_status & ~clr_bits) | events;

    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            irq_status <= 4'h0;
            irq_mask <= 4'h0;
        end else begin
            irq_status <= next_status;
            if (do_write && aw_idx == hbpwm_pkg::IDX_IRQ_MASK) begin
                irq_mask <= wr_word[3:0];
            end
        end
    end
    assign IRQ = |(irq_status & irq_mask);

    // Helper: cycles between prescaler ticks
    logic [8:0] gap;
    logic gap_ok;
    logic [2:0] last_code;
    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            gap <= 9'h000;
            gap_ok <= 1'b0;
            last_code <= 3'h0;
        end else begin
            last_code <= prescale;
            gap <= tick ? 9'h000 : 9'(gap + 9'h001);
            if (prescale != last_code) begin
                gap_ok <= 1'b0;
            end else if (tick) begin
                gap_ok <= 1'b1;
            end
        end
    end

    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!NRST);

    chk_boot_bridge_mode: assert property (
        !ctrl_written |-> bridge && hoff && !global_en)
        else $error("not in bridge mode before first control write");
    chk_trip_clears_en: assert property (
        trip_fire |=> !global_en ##0 irq_status[hbpwm_pkg::BIT_IRQ_TRIP])
        else $error("trip did not clear enable and flag interrupt");
    chk_disabled_low: assert property (
        !global_en |=> PWM_OUT == 6'h00)
        else $error("outputs active while globally disabled");
    chk_tick_spacing: assert property (
        tick && gap_ok && $stable(prescale) |->
        {1'b0, gap} == {2'h0, mask})
        else $error("prescaler tick spacing wrong");
    chk_irq_clear: assert property (
        do_write && aw_idx == hbpwm_pkg::IDX_IRQ_CLEAR && events == 4'h0
        |=> !IRQ)
        else $error("interrupt still pending after clear write");
    chk_wrap_flag: assert property (
        wrap[0] |=> irq_status[hbpwm_pkg::BIT_IRQ_WRAP0])
        else $error("period wrap did not set status");
    chk_standard_pass: assert property (
        !bridge && global_en && main_ctrl[13:11] == 3'h0 && !hoff &&
        !main_ctrl[hbpwm_pkg::BIT_INV_ALL] |=> PWM_OUT == $past(raw))
        else $error("standard mode did not pass pair outputs");

    cov_trip: cover property (trip_fire ##1 IRQ);
    cov_bridge_drive: cover property (bridge && bena && !hoff &&
        global_en && shaped[0]);
    cov_std_pwm: cover property (!bridge && global_en ##1 PWM_OUT[1]);

endmodule : six_channel_hbridge_pwm
`default_nettype wire

/* test/hbridge_stage_model.sv */
`timescale 1ns/1ps
`default_nettype none
module hbridge_stage_model (
    input wire logic [5:0] gate,
    input wire logic fault_req,
    output logic trip_n
);
    // Fault line is open drain with a pull-up, so a released line reads 1
    assign trip_n = (fault_req && gate !== 6'hxx) ? 1'b0 : 1'b1;
endmodule : hbridge_stage_model
`default_nettype wire

/* test/six_channel_hbridge_pwm_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module six_channel_hbridge_pwm_tb;
    logic CLK_SYS = 1'b0;
    logic NRST = 1'b0;
    logic [31:0] AWADDR = 32'h0, WDATA = 32'h0, ARADDR = 32'h0;
    logic AWVALID = 1'b0, WVALID = 1'b0, BREADY = 1'b0;
    logic ARVALID = 1'b0, RREADY = 1'b0;
    logic AWREADY, WREADY, BVALID, ARREADY, RVALID, IRQ, TRIP_N;
    logic [1:0] BRESP, RRESP, resp;
    logic [31:0] RDATA, rdat;
    logic [5:0] PWM_OUT;
    logic fault_req = 1'b0;
    int n_fail = 0;
    int check_count = 0;

    six_channel_hbridge_pwm i_dut (.CLK_SYS(CLK_SYS), .NRST(NRST),
        .AWADDR(AWADDR), .AWVALID(AWVALID), .AWREADY(AWREADY),
        .WDATA(WDATA), .WSTRB(4'hf), .WVALID(WVALID), .WREADY(WREADY),
        .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY),
        .ARADDR(ARADDR), .ARVALID(ARVALID), .ARREADY(ARREADY),
        .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY),
        .TRIP_N(TRIP_N), .PWM_OUT(PWM_OUT), .IRQ(IRQ));
    hbridge_stage_model i_stage (.gate(PWM_OUT), .fault_req(fault_req),
        .trip_n(TRIP_N));

    initial begin
        forever #50 CLK_SYS = ~CLK_SYS;
    end

    task automatic end_sim;
        if (n_fail == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : end_sim

    task automatic chk(input string what, input logic [31:0] exp,
            input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // No cycle limit here: only the watchdog ends a hung transfer
    task automatic wr(input logic [4:0] idx, input logic [31:0] d);
        logic done;
        done = 1'b0;
        resp = 2'h3;
        @(posedge CLK_SYS);
        AWADDR <= {25'h0, idx, 2'h0};
        WDATA <= d;
        AWVALID <= 1'b1;
        WVALID <= 1'b1;
        BREADY <= 1'b1;
        while (!done) begin
            @(posedge CLK_SYS);
            if (AWVALID && AWREADY) AWVALID <= 1'b0;
            if (WVALID && WREADY) WVALID <= 1'b0;
            if (BVALID) begin
                resp = BRESP;
                BREADY <= 1'b0;
                done = 1'b1;
            end
        end
    endtask : wr

    task automatic rd(input logic [4:0] idx);
        logic done;
        done = 1'b0;
        resp = 2'h3;
        rdat = 32'hdead0bad;
        @(posedge CLK_SYS);
        ARADDR <= {25'h0, idx, 2'h0};
        ARVALID <= 1'b1;
        RREADY <= 1'b1;
        while (!done) begin
            @(posedge CLK_SYS);
            if (ARVALID && ARREADY) ARVALID <= 1'b0;
            if (RVALID) begin
                rdat = RDATA;
                resp = RRESP;
                RREADY <= 1'b0;
                done = 1'b1;
            end
        end
    endtask : rd

    task automatic wait_lvl(input int b, input logic lvl, output int n);
        n = 0;
        do begin
            @(posedge CLK_SYS);
            n++;
        end while (PWM_OUT[b] !== lvl && n < 6000);
        if (PWM_OUT[b] !== lvl) begin
            n_fail++;
            $display("wrong value output %0d expected %b seen %b", b, lvl,
                PWM_OUT[b]);
        end
    endtask : wait_lvl

    // Second pass skips the period disturbed by any register change
    task automatic meas(input int b, output int w, output int p);
        int a;
        repeat (2) begin
            wait_lvl(b, 1'b0, a);
            wait_lvl(b, 1'b1, a);
            wait_lvl(b, 1'b0, w);
            wait_lvl(b, 1'b1, a);
        end
        p = w + a;
    endtask : meas

    task automatic t_reset;
        rd(5'h00);
        chk("main control", 32'h12, rdat);
        chk("outputs", 32'h0, {26'h0, PWM_OUT});
        chk("irq", 32'h0, {31'h0, IRQ});
        rd(5'h1f);
        chk("unmapped rresp", 32'h2, {30'h0, resp});
        chk("unmapped rdata", 32'h0, rdat);
        wr(5'h1f, 32'h1);
        chk("unmapped bresp", 32'h2, {30'h0, resp});
        wr(5'h00, 32'h13);
        repeat (4) @(posedge CLK_SYS);
        chk("bridge off", 32'h5, {28'h0, PWM_OUT[3:0]});
        wr(5'h00, 32'h12);
        repeat (4) @(posedge CLK_SYS);
        chk("disabled", 32'h0, {26'h0, PWM_OUT});
    endtask : t_reset

    task automatic t_pairs;
        int w, p;
        for (int k = 0; k < 3; k++) begin
            wr(5'(1 + 4 * k), 32'h2);
            wr(5'(2 + 4 * k), 32'h5);
            wr(5'(3 + 4 * k), (k == 1) ? 32'h3 : 32'h8);
            wr(5'(4 + 4 * k), 32'h9);
        end
        wr(5'h00, 32'h9);
        for (int k = 0; k < 3; k++) begin
            meas(2 * k, w, p);
            chk("high width", 32'd6, w);
            chk("period", 32'd20, p);
            meas(2 * k + 1, w, p);
            // Low side ends early at its own compare on pair 1
            chk("low width", (k == 1) ? 32'd8 : 32'd12, w);
        end
    endtask : t_pairs

    task automatic t_prescale;
        int w, p;
        for (int c = 0; c < 8; c++) begin
            wr(5'h00, 32'h9 | (c << 6));
            meas(0, w, p);
            chk("prescaled period", 10 * (2 << c), p);
            chk("prescaled width", 3 * (2 << c), w);
        end
    endtask : t_prescale

    task automatic t_load;
        int w, p;
        wr(5'h00, 32'h1);
        wr(5'h02, 32'h7);
        meas(0, w, p);
        chk("held compare", 32'd6, w);
        wr(5'h00, 32'h9);
        meas(0, w, p);
        chk("loaded compare", 32'd10, w);
    endtask : t_load

    task automatic t_trip;
        int n;
        wr(5'h10, 32'h1);
        wr(5'h00, 32'h409);
        fault_req <= 1'b1;
        n = 0;
        while (IRQ !== 1'b1 && n < 20) begin
            @(posedge CLK_SYS);
            n++;
        end
        repeat (2) @(posedge CLK_SYS);
        chk("trip irq", 32'h1, {31'h0, IRQ});
        chk("trip outputs", 32'h0, {26'h0, PWM_OUT});
        fault_req <= 1'b0;
        rd(5'h00);
        chk("trip control", 32'h408, rdat);
        wr(5'h0e, 32'h1);
        repeat (2) @(posedge CLK_SYS);
        chk("cleared irq", 32'h0, {31'h0, IRQ});
        wr(5'h10, 32'h0);
        fault_req <= 1'b1;
        repeat (10) @(posedge CLK_SYS);
        fault_req <= 1'b0;
        chk("masked irq", 32'h0, {31'h0, IRQ});
        wr(5'h10, 32'h1);
        repeat (2) @(posedge CLK_SYS);
        chk("unmasked irq", 32'h1, {31'h0, IRQ});
        rd(5'h0f);
        chk("trip status", 32'h1, {31'h0, rdat[0]});
        repeat (2) @(posedge CLK_SYS);
        chk("read cleared irq", 32'h0, {31'h0, IRQ});
    endtask : t_trip

    // Pair 0 compares are rise 2, fall 7, low fall 8, length 9 here
    task automatic t_bridge;
        int w, p;
        wr(5'h00, 32'h20f);
        meas(0, w, p);
        chk("bridge dir1 width", 32'd10, w);
        chk("bridge dir1 idle", 32'h0, {30'h0, PWM_OUT[3:2]});
        wr(5'h00, 32'h20b);
        meas(2, w, p);
        chk("bridge dir0 width", 32'd6, w);
        chk("bridge dir0 idle", 32'h0, {30'h0, PWM_OUT[1:0]});
        wr(5'h00, 32'h00b);
        repeat (4) @(posedge CLK_SYS);
        chk("bridge disabled", 32'h0, {28'h0, PWM_OUT[3:0]});
        wr(5'h00, 32'h829);
        meas(2, w, p);
        chk("inverted width", 32'd14, w);
        meas(1, w, p);
        chk("double inverted width", 32'd16, w);
        wr(5'h0d, 32'h1);
        rd(5'h11);
        chk("restart count", 32'h1, rdat);
    endtask : t_bridge

    initial begin
        repeat (20) @(posedge CLK_SYS);
        NRST <= 1'b1;
        t_reset;
        t_pairs;
        t_prescale;
        t_load;
        t_trip;
        t_bridge;
        end_sim;
    end

    // Whole plan needs roughly 20000 cycles
    initial begin
        repeat (60000) @(posedge CLK_SYS);
        n_fail++;
        end_sim;
    end
endmodule : six_channel_hbridge_pwm_tb
`default_nettype wire
